// ===== cfsup_host.sv
// Bus controller model for the two-wire status port
`timescale 1ns/1ns
`default_nettype none
module cfsup_host (
   // Target enables, low pulls the line
   input wire logic sclOe,
   input wire logic sdaOe,
   // Resolved line levels
   output logic scl,
   output logic sda
);
   logic sclDrv = 1'b1;
   logic sdaDrv = 1'b1;
   // Pull-ups: a released line reads high
   assign scl = sclDrv & sclOe;
   assign sda = sdaDrv & sdaOe;
   task automatic start;
      sdaDrv = 1'b1;
      #100 sclDrv = 1'b1;
      #200 sdaDrv = 1'b0;
      #200 sclDrv = 1'b0;
      #100;
   endtask
   task automatic stop;
      sdaDrv = 1'b0;
      #100 sclDrv = 1'b1;
      #200 sdaDrv = 1'b1;
      #200;
   endtask
   // Eight bits then the acknowledge slot, most significant first
   task automatic xb(input logic [8:0] w, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         sdaDrv = w[i];
         #150 sclDrv = 1'b1;
         for (int k = 0; k < 50 && !scl; k++) #10;
         #100 r[i] = sda;
         #50 sclDrv = 1'b0;
         #100;
      end
   endtask
endmodule // cfsup_host
`default_nettype wire

// ===== cfsup_i2c.sv
// I2C target engine with glitch filter and bus timeout
`timescale 1ns/1ns
`default_nettype none
module cfsup_i2c (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Synchronised bus lines
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOe,
   output logic sclOe,
   // Register port
   output logic [7:0] regAddr,
   output logic [7:0] wrData,
   output logic wrStb,
   output logic rdStb,
   input wire logic [7:0] rdData,
   input wire logic addrValid
);
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_DEV = 6'b000010,
      ST_ADDR = 6'b000100,
      ST_WR = 6'b001000,
      ST_RD = 6'b010000,
      ST_ACK = 6'b100000
   } cfsup_st_type;

   localparam int GW = cfsup_pkg::cfsup_clog2(cfsup_pkg::GLITCH_CYC + 1) + 1;
   localparam int TW = cfsup_pkg::cfsup_clog2(cfsup_pkg::BUSTO_CYC + 1);

   // ------------------------------------------------------------
   // Glitch filter
   // ------------------------------------------------------------
   logic sclF_reg, sclF_next, sdaF_reg, sdaF_next;
   logic [GW-1:0] sclC_reg, sclC_next, sdaC_reg, sdaC_next;
   logic sclP_reg, sdaP_reg;

   always_comb begin
      sclF_next = sclF_reg;
      sdaF_next = sdaF_reg;
      sclC_next = '0;
      sdaC_next = '0;
      if (sclIn != sclF_reg) begin
         sclC_next = sclC_reg + 1'b1;
         if (sclC_reg >= GW'(cfsup_pkg::GLITCH_CYC)) sclF_next = sclIn;
      end
      if (sdaIn != sdaF_reg) begin
         sdaC_next = sdaC_reg + 1'b1;
         if (sdaC_reg >= GW'(cfsup_pkg::GLITCH_CYC)) sdaF_next = sdaIn;
      end
   end

   wire logic sclRise = sclF_reg & ~sclP_reg;
   wire logic sclFall = ~sclF_reg & sclP_reg;
   wire logic startC = sclF_reg & sclP_reg & sdaP_reg & ~sdaF_reg;
   wire logic stopC = sclF_reg & sclP_reg & ~sdaP_reg & sdaF_reg;

   // ------------------------------------------------------------
   // Protocol engine
   // ------------------------------------------------------------
   cfsup_st_type st_reg, st_next, ret_reg, ret_next;
   logic [7:0] sh_reg, sh_next, addr_reg, addr_next;
   logic [3:0] bit_reg, bit_next;
   logic drvLow_reg, drvLow_next, nack_reg, nack_next, rnw_reg, rnw_next;
   logic busy_reg, busy_next;
   logic [TW-1:0] to_reg, to_next;

   always_comb begin
      st_next = st_reg;
      ret_next = ret_reg;
      sh_next = sh_reg;
      addr_next = addr_reg;
      bit_next = bit_reg;
      drvLow_next = drvLow_reg;
      nack_next = nack_reg;
      rnw_next = rnw_reg;
      busy_next = busy_reg;
      to_next = busy_reg ? to_reg + 1'b1 : '0;
      wrStb = 1'b0;
      rdStb = 1'b0;
      if (startC) begin
         st_next = ST_DEV;
         bit_next = '0;
         drvLow_next = 1'b0;
         busy_next = 1'b1;
         to_next = '0;
      end else if (stopC ||
            to_reg >= TW'(cfsup_pkg::BUSTO_CYC)) begin
         st_next = ST_IDLE;
         drvLow_next = 1'b0;
         busy_next = 1'b0;
      end else begin
         unique case (st_reg)
            ST_IDLE: begin
            end
            ST_DEV, ST_ADDR, ST_WR: begin
               if (sclRise) begin
                  sh_next = {sh_reg[6:0], sdaF_reg};
                  bit_next = bit_reg + 1'b1;
               end
               if (sclFall && bit_reg == 4'd8) begin
                  bit_next = '0;
                  ret_next = st_reg;
                  st_next = ST_ACK;
                  nack_next = 1'b0;
                  if (st_reg == ST_DEV) begin
                     rnw_next = sh_reg[0];
                     if (sh_reg[7:1] != cfsup_pkg::I2C_ADDR) begin
                        st_next = ST_IDLE;
                     end else if (sh_reg[0]) begin
                        rdStb = 1'b1;
                        sh_next = addrValid ? rdData : cfsup_pkg::UNMAPPED_DATA;
                        addr_next = addr_reg + 1'b1;
                     end
                  end else if (st_reg == ST_ADDR) begin
                     addr_next = sh_reg;
                     nack_next = 1'b0;
                  end else begin
                     wrStb = 1'b1;
                     addr_next = addr_reg + 1'b1;
                  end
                  drvLow_next = st_next == ST_ACK;
               end
            end
            ST_ACK: begin
               if (sclFall) begin
                  drvLow_next = 1'b0;
                  if (nack_reg) st_next = ST_IDLE;
                  else if (ret_reg == ST_DEV && rnw_reg) begin
                     st_next = ST_RD;
                     drvLow_next = ~sh_reg[7];
                  end else if (ret_reg == ST_DEV) st_next = ST_ADDR;
                  else st_next = ST_WR;
               end
            end
            ST_RD: begin
               if (sclFall) begin
                  bit_next = bit_reg + 1'b1;
                  sh_next = {sh_reg[6:0], 1'b1};
                  drvLow_next = (bit_reg != 4'd7) & ~sh_reg[6];
                  if (bit_reg == 4'd8) begin
                     bit_next = '0;
                     rdStb = 1'b1;
                     sh_next = addrValid ? rdData : cfsup_pkg::UNMAPPED_DATA;
                     addr_next = addr_reg + 1'b1;
                     drvLow_next = ~sh_next[7];
                  end
               end
               if (sclRise && bit_reg == 4'd8 && sdaF_reg) st_next = ST_IDLE;
            end
            default: st_next = ST_IDLE;
         endcase
      end
      // Undefined register address: refuse it and drop to idle
      if (st_reg == ST_ADDR && sclFall && bit_reg == 4'd8 &&
            !addrValid) begin
         st_next = ST_IDLE;
         drvLow_next = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclF_reg <= 1'b1;
         sdaF_reg <= 1'b1;
         sclC_reg <= '0;
         sdaC_reg <= '0;
         sclP_reg <= 1'b1;
         sdaP_reg <= 1'b1;
         st_reg <= ST_IDLE;
         ret_reg <= ST_IDLE;
         sh_reg <= '0;
         addr_reg <= '0;
         bit_reg <= '0;
         drvLow_reg <= 1'b0;
         nack_reg <= 1'b0;
         rnw_reg <= 1'b0;
         busy_reg <= 1'b0;
         to_reg <= '0;
      end else begin
         sclF_reg <= sclF_next;
         sdaF_reg <= sdaF_next;
         sclC_reg <= sclC_next;
         sdaC_reg <= sdaC_next;
         sclP_reg <= sclF_reg;
         sdaP_reg <= sdaF_reg;
         st_reg <= st_next;
         ret_reg <= ret_next;
         sh_reg <= sh_next;
         addr_reg <= addr_next;
         bit_reg <= bit_next;
         drvLow_reg <= drvLow_next;
         nack_reg <= nack_next;
         rnw_reg <= rnw_next;
         busy_reg <= busy_next;
         to_reg <= to_next;
      end
   end

   // Register access is single-cycle, so the clock is never stretched
   assign sclOe = 1'b1;
   assign sdaOe = ~drvLow_reg;
   assign regAddr = (st_reg == ST_ADDR) ? sh_reg : addr_reg;
   assign wrData = sh_reg;
endmodule // cfsup_i2c
`default_nettype wire

// ===== cfsup_pkg.sv
// Shared constants for the charger fault supervisor
package cfsup_pkg;
   // -------------------------------------------------------------
   // Clock and timing
   // -------------------------------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int ALERT_US = 256;
   localparam int ALERT_CYC = (ALERT_US * (CLK_HZ / 1000000));
   localparam int RETRY_S = 1;
   localparam int RETRY_CYC = RETRY_S * CLK_HZ;
   localparam int BUSTO_S = 2;
   localparam int BUSTO_CYC = BUSTO_S * CLK_HZ;
   localparam int SPIKE_NS = 50;
   localparam int GLITCH_CYC = (SPIKE_NS * (CLK_HZ / 1000000) + 999) / 1000;
   // -------------------------------------------------------------
   // I2C target
   // -------------------------------------------------------------
   localparam logic [6:0] I2C_ADDR = 7'h6b;
   localparam logic [7:0] UNMAPPED_DATA = 8'hff;
   // -------------------------------------------------------------
   // Register map (block-local choice)
   // -------------------------------------------------------------
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_FLAG = 8'h01;
   localparam logic [7:0] REG_MASK = 8'h02;
   localparam logic [7:0] REG_CTRL = 8'h03;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // Status and flag bit positions
   localparam int B_IOV = 0;
   localparam int B_IUV = 1;
   localparam int B_PGOOD = 2;
   localparam int B_BOV = 3;
   localparam int B_REV = 4;
   localparam int B_DRV = 5;
   localparam int B_TSH = 6;
   localparam int B_ROV = 7;
   // Control bit positions
   localparam int C_CHGEN = 0;
   localparam int C_REVEN = 1;
   localparam int NUM_FAULT = 9;

   // Ceiling of log2, used for counter widths
   function automatic int cfsup_clog2(input int v);
      int r;
      r = 0;
      while ((1 << r) < v) r++;
      return r;
   endfunction
endpackage

// ===== cfsup_props.sv
// Concurrent checks on the charger fault supervisor ports
`timescale 1ns/1ns
`default_nettype none
module cfsup_props (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Comparator inputs
   input wire logic inputOvSetPinTrip,
   input wire logic inputOvIntTrip,
   input wire logic batteryOvervoltTrip,
   input wire logic reverseUndervoltTrip,
   input wire logic driverSupplyLowTrip,
   input wire logic driverSupplyHighTrip,
   input wire logic regulatorLowTrip,
   input wire logic overTemperatureTrip,
   // Watched outputs
   input wire logic switchEnable,
   input wire logic highSideBlock,
   input wire logic outputDischargeSink,
   input wire logic timersSuspend,
   input wire logic reverseActive,
   input wire logic alertOe,
   input wire logic powerGoodPinOe,
   input wire logic chargeStatePinAOe
);
   logic [12:0] lowCnt_reg;
   logic [12:0] lowCnt_next;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // Low cycles of the alert so far; a slow pulse shows as a wrong count
   always_comb lowCnt_next = alertOe ? 13'h0 : lowCnt_reg + 13'h1;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) lowCnt_reg <= 13'h0;
      else lowCnt_reg <= lowCnt_next;
   end
   // Five samples cover the two-flop chain plus the control register
   sequence s_held(t);
      t [*5];
   endsequence
   property p_inOv;
      s_held(inputOvSetPinTrip || inputOvIntTrip) |->
         !switchEnable && powerGoodPinOe;
   endproperty
   property p_batOv;
      s_held(batteryOvervoltTrip) |-> highSideBlock && outputDischargeSink
         && timersSuspend && !switchEnable;
   endproperty
   property p_batRel;
      s_held(!batteryOvervoltTrip) |-> !highSideBlock && !timersSuspend;
   endproperty
   property p_drv;
      s_held(driverSupplyLowTrip || driverSupplyHighTrip) |->
         !switchEnable && chargeStatePinAOe;
   endproperty
   property p_reg;
      s_held(regulatorLowTrip) |-> !switchEnable && chargeStatePinAOe;
   endproperty
   property p_tsh;
      s_held(overTemperatureTrip) |-> !switchEnable;
   endproperty
   property p_revUv;
      s_held(reverseUndervoltTrip) |-> !reverseActive;
   endproperty
   property p_alert;
      $rose(alertOe) |-> lowCnt_reg == 13'd5120;
   endproperty
   a_inOv: assert property (p_inOv)
      else $error("input over-voltage not handled");
   a_batOv: assert property (p_batOv)
      else $error("battery over-voltage not handled");
   a_batRel: assert property (p_batRel)
      else $error("battery over-voltage block not released");
   a_drv: assert property (p_drv)
      else $error("driver supply fault not handled");
   a_reg: assert property (p_reg)
      else $error("regulator low not handled");
   a_tsh: assert property (p_tsh)
      else $error("over-temperature kept switching");
   a_revUv: assert property (p_revUv)
      else $error("reverse mode kept after under-voltage");
   a_alert: assert property (p_alert)
      else $error("alert pulse length wrong");
endmodule // cfsup_props
bind cfsup_top cfsup_props i_cfsup_props (.*);
`default_nettype wire

// ===== cfsup_sync.sv
// Two-flop synchroniser bank for asynchronous inputs
`timescale 1ns/1ns
`default_nettype none
module cfsup_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] out_next;

   always_comb begin
      meta_next = din;
      out_next = meta_reg;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         dout <= '0;
      end else begin
         meta_reg <= meta_next;
         dout <= out_next;
      end
   end
endmodule // cfsup_sync
`default_nettype wire

// ===== cfsup_top.sv
// Charger fault supervisor with I2C status port
// What this block does
// - Disable charger when input exceeds the lower over-voltage threshold.
// - Input over-voltage: alert, set status and flag, drop power good.
// - Disable charger when input falls below the higher under-voltage limit.
// - Input under-voltage: alert, set status and flag, drop power good.
// - Battery over-voltage stops switching at once until released.
// - Battery over-voltage enables discharge sink and pauses both timers.
// - Charge over-current stops charging, retries after one second.
// - Reverse over-voltage halts switching, alerts, resumes when it clears.
// - Reverse under-voltage stops, clears reverse enable and status, flags.
// - Driver supply low stops converter, alerts, flags, shows disabled.
// - Driver supply high stops converter, alerts, flags, shows disabled.
// - Driver supply recovered restarts switching in configured mode.
// - Regulator low stops converter, shows disabled, resumes on recovery.
// - Over-temperature stops converter, sets status, flag, alert.
// - Answer as I2C target at address 0x6B.
// - Reads of undefined locations return 0xFF.
// - Bus works at 100 k, 400 k and 1 M bit rates.
// - START without STOP for over two seconds resets the bus logic.
// - Bytes are eight bits, MSB first, each followed by acknowledge.
// - Target may hold the clock low between bytes; this block never does, sclOe is tied high.
// - Each alert is a 256 us low pulse; flag alerts obey the mask, power-good changes and reverse OV in reverse mode do not.
// - Flags latch on status rising edge, except power good (never) and reverse (on reverse under-voltage), and clear after being read.
// - Undefined register address gets a not-acknowledge and idle.
`timescale 1ns/1ns
`default_nettype none
module cfsup_top (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Comparator inputs (asynchronous)
   input wire logic inputOvSetPinTrip,
   input wire logic inputOvIntTrip,
   input wire logic inputUvSetPinTrip,
   input wire logic inputUvIntTrip,
   input wire logic batteryOvervoltTrip,
   input wire logic chargeOvercurrentTrip,
   input wire logic reverseOvervoltTrip,
   input wire logic reverseUndervoltTrip,
   input wire logic driverSupplyLowTrip,
   input wire logic driverSupplyHighTrip,
   input wire logic regulatorLowTrip,
   input wire logic overTemperatureTrip,
   // I2C pins
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOe,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Converter control
   output logic switchEnable,
   output logic highSideBlock,
   output logic outputDischargeSink,
   output logic timersSuspend,
   output logic reverseActive,
   // Status pins (open drain, low when oe low)
   output logic alertOut,
   output logic alertOe,
   output logic powerGoodPinOut,
   output logic powerGoodPinOe,
   output logic chargeStatePinAOut,
   output logic chargeStatePinAOe,
   output logic chargeStatePinBOut,
   output logic chargeStatePinBOe
);
   localparam int RW = cfsup_pkg::cfsup_clog2(cfsup_pkg::RETRY_CYC + 1);
   localparam int AW = cfsup_pkg::cfsup_clog2(cfsup_pkg::ALERT_CYC + 1);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [11:0] rawIn, syncIn;
   logic [1:0] busSync;
   assign rawIn = {overTemperatureTrip, regulatorLowTrip, driverSupplyHighTrip,
      driverSupplyLowTrip, reverseUndervoltTrip, reverseOvervoltTrip,
      chargeOvercurrentTrip, batteryOvervoltTrip, inputUvIntTrip,
      inputUvSetPinTrip, inputOvIntTrip, inputOvSetPinTrip};

   cfsup_sync #(.W(12)) u_fsync (
      .clk(ref_clk),
      .rst(sys_rst),
      .din(rawIn),
      .dout(syncIn)
   );
   cfsup_sync #(.W(2)) u_bsync (
      .clk(ref_clk),
      .rst(sys_rst),
      .din(~{sclIn, sdaIn}), // Held inverted so reset reads as an idle bus
      .dout(busSync)
   );

   // Each trip is high when the input passes that threshold, so the
   // lower OV threshold and higher UV threshold reduce to an OR.
   wire logic inOv = syncIn[0] | syncIn[1];
   wire logic inUv = syncIn[2] | syncIn[3];
   wire logic batOv = syncIn[4];
   wire logic chgOc = syncIn[5];
   wire logic revOv = syncIn[6];
   wire logic revUv = syncIn[7];
   wire logic drvBad = syncIn[8] | syncIn[9];
   wire logic regLow = syncIn[10];
   wire logic over_temperature_trip = syncIn[11];

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   logic [7:0] regAddr, wrData, rdData;
   logic wrStb, rdStb, addrValid;
   logic [7:0] status, flag_reg, flag_next, mask_reg, mask_next;
   logic [7:0] ctrl_reg, ctrl_next, statP_reg;

   cfsup_i2c u_i2c (
      .clk(ref_clk),
      .rst(sys_rst),
      .sclIn(~busSync[1]),
      .sdaIn(~busSync[0]),
      .sdaOe(sdaOe),
      .sclOe(sclOe),
      .regAddr(regAddr),
      .wrData(wrData),
      .wrStb(wrStb),
      .rdStb(rdStb),
      .rdData(rdData),
      .addrValid(addrValid)
   );
   assign sclOut = 1'b0;
   assign sdaOut = 1'b0;

   always_comb begin
      addrValid = regAddr <= cfsup_pkg::REG_CTRL;
      unique case (regAddr)
         cfsup_pkg::REG_STATUS: rdData = status;
         cfsup_pkg::REG_FLAG: rdData = flag_reg;
         cfsup_pkg::REG_MASK: rdData = mask_reg;
         cfsup_pkg::REG_CTRL: rdData = ctrl_reg;
         default: rdData = cfsup_pkg::UNMAPPED_DATA;
      endcase
   end

   // ------------------------------------------------------------
   // Fault state
   // ------------------------------------------------------------
   logic [RW-1:0] retry_reg, retry_next;
   logic [AW-1:0] alert_reg, alert_next;
   logic revUvP_reg, revOvP_reg;
   logic [7:0] rise;
   logic alertEvt, chgFault, convStop, powerGood;

   always_comb begin
      powerGood = ~inOv & ~inUv;
      status = '0;
      status[cfsup_pkg::B_IOV] = inOv;
      status[cfsup_pkg::B_IUV] = inUv;
      status[cfsup_pkg::B_PGOOD] = powerGood;
      status[cfsup_pkg::B_BOV] = batOv;
      status[cfsup_pkg::B_REV] = reverseActive;
      status[cfsup_pkg::B_DRV] = drvBad;
      status[cfsup_pkg::B_TSH] = over_temperature_trip;
      status[cfsup_pkg::B_ROV] = revOv;
      rise = status & ~statP_reg;
      // Reverse exit flags through its own bit, not a status edge
      rise[cfsup_pkg::B_REV] = revUv & ~revUvP_reg & ctrl_reg[cfsup_pkg::C_REVEN];
      rise[cfsup_pkg::B_PGOOD] = 1'b0;
      // A new event wins over the read-clear in the same cycle
      flag_next = flag_reg;
      if (rdStb && regAddr == cfsup_pkg::REG_FLAG) flag_next = '0;
      flag_next = flag_next | rise;

      mask_next = mask_reg;
      ctrl_next = ctrl_reg;
      if (wrStb && regAddr == cfsup_pkg::REG_MASK) mask_next = wrData;
      if (wrStb && regAddr == cfsup_pkg::REG_CTRL) ctrl_next = wrData;
      if (reverseActive && revUv) ctrl_next[cfsup_pkg::C_REVEN] = 1'b0;

      // Retry delay after charge over-current
      retry_next = retry_reg;
      if (chgOc) retry_next = RW'(cfsup_pkg::RETRY_CYC);
      else if (retry_reg != '0) retry_next = retry_reg - 1'b1;

      // Events during a pulse do not stretch it; the flags still hold all but power-good changes
      alertEvt = |(rise & ~mask_reg) | (revOv & ~revOvP_reg & reverseActive);
      alertEvt = alertEvt | (powerGood ^ statP_reg[cfsup_pkg::B_PGOOD]);
      alert_next = alert_reg;
      if (alert_reg != '0) alert_next = alert_reg - 1'b1;
      else if (alertEvt) alert_next = AW'(cfsup_pkg::ALERT_CYC);
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flag_reg <= '0;
         mask_reg <= cfsup_pkg::MASK_RST;
         ctrl_reg <= cfsup_pkg::CTRL_RST;
         statP_reg <= '0;
         retry_reg <= '0;
         alert_reg <= '0;
         revUvP_reg <= 1'b0;
         revOvP_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
         mask_reg <= mask_next;
         ctrl_reg <= ctrl_next;
         statP_reg <= status;
         retry_reg <= retry_next;
         alert_reg <= alert_next;
         revUvP_reg <= revUv;
         revOvP_reg <= revOv;
      end
   end

   // ------------------------------------------------------------
   // Converter control and pins
   // ------------------------------------------------------------
   // Mode bits stay set through faults other than reverse under-voltage, so switching resumes as before
   assign reverseActive = ctrl_reg[cfsup_pkg::C_REVEN];
   assign convStop = drvBad | regLow | over_temperature_trip | batOv;
   assign chgFault = inOv | inUv | chgOc | (retry_reg != '0);
   always_comb begin
      if (reverseActive) begin
         switchEnable = ~convStop & ~revOv & ~revUv;
      end else begin
         switchEnable = ~convStop & ~chgFault &
            ctrl_reg[cfsup_pkg::C_CHGEN];
      end
   end
   assign highSideBlock = batOv;
   assign outputDischargeSink = batOv;
   assign timersSuspend = batOv;
   assign alertOut = 1'b0;
   assign alertOe = (alert_reg == '0);
   assign powerGoodPinOut = 1'b0;
   assign powerGoodPinOe = ~powerGood;
   // Charging shows A on, B off; disabled shows both off
   assign chargeStatePinAOut = 1'b0;
   assign chargeStatePinBOut = 1'b0;
   assign chargeStatePinAOe = ~(switchEnable & ~reverseActive);
   assign chargeStatePinBOe = 1'b1;
endmodule // cfsup_top
`default_nettype wire

// ===== cfsup_top_tb.sv
// Self-checking bench for the charger fault supervisor
`timescale 1ns/1ns
`default_nettype none
module cfsup_top_tb;
   logic ref_clk;
   logic sys_rst;
   logic [11:0] trips;
   logic scl;
   logic sda;
   logic sclOe, sdaOe;
   logic swEn;
   logic revAct;
   logic alertOe;
   logic pwrGoodOe;
   logic statAOe;
   int n_fail;
   int n_checks;
   cfsup_top i_cfsup_top (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .inputOvSetPinTrip(trips[0]), .inputOvIntTrip(trips[1]),
      .inputUvSetPinTrip(trips[2]), .inputUvIntTrip(trips[3]),
      .batteryOvervoltTrip(trips[4]), .chargeOvercurrentTrip(trips[5]),
      .reverseOvervoltTrip(trips[6]), .reverseUndervoltTrip(trips[7]),
      .driverSupplyLowTrip(trips[8]), .driverSupplyHighTrip(trips[9]),
      .regulatorLowTrip(trips[10]), .overTemperatureTrip(trips[11]),
      .sclIn(scl), .sclOut(), .sclOe(sclOe),
      .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe), .switchEnable(swEn),
      .highSideBlock(), .outputDischargeSink(), .timersSuspend(),
      .reverseActive(revAct), .alertOut(), .alertOe(alertOe),
      .powerGoodPinOut(), .powerGoodPinOe(pwrGoodOe), .chargeStatePinAOut(),
      .chargeStatePinAOe(statAOe), .chargeStatePinBOut(),
      .chargeStatePinBOe());
   cfsup_host i_cfsup_host (.sclOe(sclOe), .sdaOe(sdaOe), .scl(scl),
      .sda(sda));
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] got,
         input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic setw(input logic [11:0] v);
      @(posedge ref_clk);
      trips <= v;
      repeat (10) @(negedge ref_clk);
   endtask
   task automatic ackx(input logic [7:0] b, input logic nack);
      logic [8:0] r;
      i_cfsup_host.xb({b, 1'b1}, r);
      chk("ack", 16'(r[0]), 16'(nack));
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #10;
      i_cfsup_host.start();
      ackx(8'hd6, 1'b0);
      ackx(a, 1'b0);
      ackx(d, 1'b0);
      i_cfsup_host.stop();
   endtask
   // Reads two bytes; only the bits set in m are compared
   task automatic rd(input logic [7:0] a, input logic [7:0] e1,
         input logic [7:0] e2, input logic [7:0] m);
      logic [8:0] r;
      @(posedge ref_clk);
      #10;
      i_cfsup_host.start();
      ackx(8'hd6, 1'b0);
      ackx(a, 1'b0);
      i_cfsup_host.start();
      ackx(8'hd7, 1'b0);
      i_cfsup_host.xb(9'h1fe, r);
      chk("byte one", 16'(r[8:1] & m), 16'(e1 & m));
      i_cfsup_host.xb(9'h1ff, r);
      chk("byte two", 16'(r[8:1] & m), 16'(e2 & m));
      i_cfsup_host.stop();
   endtask
   task automatic t_bus;
      @(posedge ref_clk);
      #10;
      i_cfsup_host.start();
      ackx(8'hd4, 1'b1);
      i_cfsup_host.stop();
      i_cfsup_host.start();
      ackx(8'hd6, 1'b0);
      ackx(8'h04, 1'b1);
      i_cfsup_host.stop();
      rd(8'h02, 8'h00, 8'h00, 8'hff);
      wr(8'h03, 8'h01);
      rd(8'h03, 8'h01, 8'hff, 8'hff);
      chk("switching", 16'(swEn), 16'h1);
      chk("state pin", 16'(statAOe), 16'h0);
      $display("test bus done");
   endtask
   task automatic t_faults;
      int idx[8] = '{0, 1, 2, 3, 8, 9, 10, 11};
      foreach (idx[i]) begin
         setw(12'(1 << idx[i]));
         chk("stop", 16'(swEn), 16'h0);
         chk("state pin", 16'(statAOe), 16'h1);
         if (idx[i] < 4) chk("good pin", 16'(pwrGoodOe), 16'h1);
         setw(12'h0);
         chk("resume", 16'(swEn), 16'h1);
      end
      setw(12'h010);
      chk("bat ov", 16'(swEn), 16'h0);
      setw(12'h0);
      chk("bat ov end", 16'(swEn), 16'h1);
      $display("test faults done");
   endtask
   task automatic t_alert(input logic [7:0] msk, input int lim,
         input int exp);
      int n;
      wr(8'h02, msk);
      for (n = 0; alertOe !== 1'b1 && n < 6000; n++) @(negedge ref_clk);
      chk("alert idle", 16'(alertOe), 16'h1);
      rd(8'h01, 8'h00, 8'h00, 8'h00);
      @(posedge ref_clk);
      trips <= 12'h800;
      for (n = 0; alertOe !== 1'b0 && n < lim; n++) @(negedge ref_clk);
      for (n = 0; alertOe === 1'b0 && n < 6000; n++) @(negedge ref_clk);
      chk("alert low", 16'(n), 16'(exp));
      rd(8'h01, 8'h40, msk, 8'hff);
      rd(8'h01, 8'h00, msk, 8'hff);
      setw(12'h0);
      $display("test alert done");
   endtask
   task automatic t_rev;
      wr(8'h03, 8'h02);
      chk("reverse on", 16'(revAct), 16'h1);
      setw(12'h040);
      chk("rev ov stop", 16'(swEn), 16'h0);
      setw(12'h0);
      chk("rev ov resume", 16'(swEn), 16'h1);
      rd(8'h01, 8'h00, 8'h00, 8'h00);
      setw(12'h080);
      chk("rev exit", 16'(revAct), 16'h0);
      chk("rev stop", 16'(swEn), 16'h0);
      setw(12'h0);
      rd(8'h01, 8'h10, 8'h00, 8'h10);
      wr(8'h03, 8'h01);
      setw(12'h020);
      chk("oc stop", 16'(swEn), 16'h0);
      setw(12'h0);
      chk("oc wait", 16'(swEn), 16'h0);
      $display("test reverse done");
   endtask
   initial begin
      sys_rst = 1'b1;
      trips = 12'h0;
      n_fail = 0;
      n_checks = 0;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      t_bus;
      t_faults;
      t_alert(8'h00, 20, 5120);
      t_alert(8'h40, 40, 0);
      t_rev;
      stop_test;
   end
   initial begin
      repeat (100000) @(posedge ref_clk);
      n_fail++;
      stop_test;
   end
endmodule // cfsup_top_tb
`default_nettype wire
